// ===== ppli_map.vh
// Purpose: constants for the packed pixel palette index block
// Assumes: plain register port, 32-bit data, byte-addressed buffer space
// Notes:   buffer and registers share one address port, selected by a space bit
`ifndef PPLI_MAP_VH
`define PPLI_MAP_VH

// ----------------------------------------------------------------
// address map
// ----------------------------------------------------------------
`define PPLI_BUF_BYTES      262144
`define PPLI_BUF_AW         18
`define PPLI_REG_ID         6'h00
`define PPLI_REG_CTRL       6'h04
`define PPLI_REG_FETCH      6'h08
`define PPLI_REG_STAT       6'h0c

// ----------------------------------------------------------------
// identification fields
// ----------------------------------------------------------------
`define PPLI_ID_PROD_LO     2
`define PPLI_ID_PROD_HI_POS 26
`define PPLI_ID_REV_LO      0
`define PPLI_ID_REV_HI_POS  24
`define PPLI_ID_SIZE_POS    8
`define PPLI_ID_STRAP_POS   16
`define PPLI_ID_SIZE_CODE   8'h40
`define PPLI_STRAP_SETTLE   2'h2

// ----------------------------------------------------------------
// control fields and depth codes
// ----------------------------------------------------------------
`define PPLI_CTRL_DEPTH_LO  0
`define PPLI_CTRL_COLOR_POS 4
`define PPLI_CTRL_RESET     32'h0000_0000
`define PPLI_DEPTH_1        3'h0
`define PPLI_DEPTH_2        3'h1
`define PPLI_DEPTH_4        3'h2
`define PPLI_DEPTH_8        3'h3
`define PPLI_DEPTH_16       3'h4

`endif

// ===== ppli_pal_model.sv
// Purpose: palette table and modulator stand-in on the pixel feed
// Assumes: table preset, entry i holds the low six bits of i in each primary
// Notes:   no host path to the table here
`timescale 1ns/1ps
module ppli_pal_model (
	// clock
	input  wire        clk_sys,
	// pixel feed
	input  wire        pix_valid,
	input  wire [7:0]  pal_index,
	input  wire        pal_green_only,
	input  wire [15:0] frm_direct,
	input  wire        frm_bypass,
	// panel level
	output reg  [17:0] panel_rgb
);
	reg [17:0] lut [0:255];
	integer i;
	initial begin
		panel_rgb = 18'h0;
		for (i = 0; i < 256; i = i + 1) begin
			lut[i] = {3{i[5:0]}};
		end
	end
	always @(posedge clk_sys) begin
		if (pix_valid && frm_bypass) begin
			panel_rgb <= {frm_direct[15:11], 1'b0, frm_direct[10:5], frm_direct[4:0], 1'b0};
		end else if (pix_valid && pal_green_only) begin
			panel_rgb <= {6'h0, lut[pal_index][11:6], 6'h0};
		end else if (pix_valid) begin
			panel_rgb <= lut[pal_index];
		end
	end
endmodule

// ===== ppli_props.sv
// Purpose: port properties of the packed pixel block
// Assumes: single-cycle host strobes
// Notes:   seven strap bits vary by board, so only fixed id fields are checked
`timescale 1ns/1ps
module ppli_props #(
	parameter [5:0] PROD = 6'h2a,
	parameter [1:0] REV  = 2'h2
) (
	input wire        clk_sys,
	input wire        rst_n,
	input wire        host_space_buf,
	input wire [19:0] host_addr,
	input wire        host_wr,
	input wire        host_rd,
	input wire [31:0] host_rdata,
	input wire        pix_req,
	input wire        pix_valid,
	input wire        pal_green_only,
	input wire        frm_bypass
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	sequence s_id_rd;
		host_rd && !host_space_buf && host_addr == 20'h0;
	endsequence
	sequence s_pix_take;
		pix_req && !host_wr;
	endsequence
	a_id_prod: assert property (s_id_rd |=> host_rdata[7:2] == PROD && host_rdata[31:26] == PROD)
		else $error("product code fields wrong");
	a_id_rev: assert property (s_id_rd |=> host_rdata[1:0] == REV && host_rdata[25:24] == REV)
		else $error("revision fields wrong");
	a_id_size: assert property (s_id_rd |=> host_rdata[15:8] == 8'h40)
		else $error("buffer size code wrong");
	a_id_gap: assert property (s_id_rd |=> host_rdata[23] == 1'b0)
		else $error("bit above strap field set");
	a_rd_release: assert property (host_rd ##1 !host_rd |=> host_rdata == 32'h0)
		else $error("read data held too long");
	a_pix_answer: assert property (s_pix_take |=> pix_valid)
		else $error("pixel request not answered");
	a_pix_cause: assert property (pix_valid |-> $past(pix_req))
		else $error("pixel valid without request");
	a_bypass_color: assert property (frm_bypass |-> !pal_green_only)
		else $error("table select during bypass");
endmodule
bind ppli_top ppli_props #(.PROD(PROD), .REV(REV)) i_props (.clk_sys(clk_sys), .rst_n(rst_n),
	.host_space_buf(host_space_buf), .host_addr(host_addr), .host_wr(host_wr),
	.host_rd(host_rd), .host_rdata(host_rdata), .pix_req(pix_req), .pix_valid(pix_valid),
	.pal_green_only(pal_green_only), .frm_bypass(frm_bypass));

// ===== ppli_top.v
// Purpose: packed pixel buffer, identification register and palette index feed
// Assumes: one clock, host port with read data one cycle after the strobe
// Notes:   buffer is flip-flops and large; the size parameter can shrink it
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "ppli_map.vh"

module ppli_top #(
	parameter BUF_AW     = `PPLI_BUF_AW,
	parameter [5:0] PROD = 6'h2a,
	parameter [1:0] REV  = 2'h2
) (
	// clock and reset
	input  wire        clk_sys,
	input  wire        rst_n,
	// host register and buffer port
	input  wire        host_space_buf,
	input  wire [19:0] host_addr,
	input  wire [31:0] host_wdata,
	input  wire        host_wr,
	input  wire        host_rd,
	output reg  [31:0] host_rdata,
	// board straps
	input  wire [6:0]  config_strap_pins,
	// pixel request from panel timing
	input  wire        pix_req,
	// palette side
	output reg         pix_valid,
	output reg  [7:0]  pal_index,
	output reg         pal_green_only,
	output reg  [15:0] frm_direct,
	output reg         frm_bypass
);

	// PROD and REV defaults are arbitrary values
	localparam DEPTH_BYTES = (1 << BUF_AW);

	// ----------------------------------------------------------------
	// strap capture after reset release
	// ----------------------------------------------------------------
	reg [6:0] strap_s1;
	reg [6:0] strap_s2;
	reg [6:0] strap_held;
	reg       strap_done;
	reg [1:0] strap_age;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strap_s1   <= 7'h00;
			strap_s2   <= 7'h00;
			strap_held <= 7'h00;
			strap_done <= 1'b0;
			strap_age  <= 2'h0;
		end else begin
			strap_s1 <= config_strap_pins;
			strap_s2 <= strap_s1;
			// second stage holds pin levels only after two edges, not the reset zeros
			if (strap_age != `PPLI_STRAP_SETTLE) begin
				strap_age <= strap_age + 2'h1;
			end else if (!strap_done) begin
				strap_held <= strap_s2;
				strap_done <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// identification word
	// ----------------------------------------------------------------
	wire [31:0] id_word;
	assign id_word = {PROD, REV, 1'b0, strap_held, `PPLI_ID_SIZE_CODE, PROD, REV};

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	reg [2:0]        depth;
	reg              color;
	reg [BUF_AW-1:0] fetch_base;
	reg [BUF_AW-1:0] fetch_ptr;
	reg [2:0]        slot;

	function is_reg;
		input [19:0] a;
		input [5:0]  off;
		begin
			is_reg = (a[19:6] == 14'h0000) && (a[5:0] == off);
		end
	endfunction

	wire reg_wr;
	wire buf_wr;
	assign reg_wr = host_wr && !host_space_buf;
	assign buf_wr = host_wr && host_space_buf;

	// ----------------------------------------------------------------
	// display buffer, byte wide flip-flops
	// ----------------------------------------------------------------
	reg [7:0] mem [0:DEPTH_BYTES-1];
	wire [BUF_AW-1:0] haddr;
	assign haddr = host_addr[BUF_AW-1:0];

	// writes place byte 0 of the write word at the addressed byte
	always @(posedge clk_sys) begin
		if (buf_wr) begin
			mem[haddr] <= host_wdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// pixel walker
	// ----------------------------------------------------------------
	reg [2:0] last_slot;
	always @* begin
		case (depth)
		`PPLI_DEPTH_1: last_slot = 3'h7;
		`PPLI_DEPTH_2: last_slot = 3'h3;
		`PPLI_DEPTH_4: last_slot = 3'h1;
		default:       last_slot = 3'h0;
		endcase
	end

	// sixteen bit pixels take the even byte and its odd partner
	wire [BUF_AW-1:0] pair_lo;
	wire [BUF_AW-1:0] pair_hi;
	assign pair_lo = (depth == `PPLI_DEPTH_16) ? {fetch_ptr[BUF_AW-1:1], 1'b0} : fetch_ptr;
	assign pair_hi = {fetch_ptr[BUF_AW-1:1], 1'b1};

	wire [15:0] fetch_word;
	assign fetch_word = {mem[pair_hi], mem[pair_lo]};

	wire [7:0]  u_index;
	wire [15:0] u_direct;
	wire        u_bypass;

	ppli_unpack u_unpack (
		.word   (fetch_word),
		.depth  (depth),
		.slot   (slot),
		.color  (color),
		.index  (u_index),
		.direct (u_direct),
		.bypass (u_bypass)
	);

	wire [BUF_AW-1:0] ptr_step;
	assign ptr_step = (depth == `PPLI_DEPTH_16) ? {{(BUF_AW-2){1'b0}}, 2'h2}
	                                            : {{(BUF_AW-1){1'b0}}, 1'b1};

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			depth          <= 3'h0;
			color          <= 1'b0;
			fetch_base     <= {BUF_AW{1'b0}};
			fetch_ptr      <= {BUF_AW{1'b0}};
			slot           <= 3'h0;
			pix_valid      <= 1'b0;
			pal_index      <= 8'h00;
			pal_green_only <= 1'b0;
			frm_direct     <= 16'h0000;
			frm_bypass     <= 1'b0;
		end else begin
			pix_valid <= 1'b0;
			if (reg_wr && is_reg(host_addr, `PPLI_REG_CTRL)) begin
				depth     <= host_wdata[`PPLI_CTRL_DEPTH_LO +: 3];
				color     <= host_wdata[`PPLI_CTRL_COLOR_POS];
				fetch_ptr <= fetch_base;
				slot      <= 3'h0;
			end else if (reg_wr && is_reg(host_addr, `PPLI_REG_FETCH)) begin
				fetch_base <= host_wdata[BUF_AW-1:0];
				fetch_ptr  <= host_wdata[BUF_AW-1:0];
				slot       <= 3'h0;
			end else if (pix_req) begin
				pix_valid      <= 1'b1;
				pal_index      <= u_index;
				pal_green_only <= !color && !u_bypass;
				frm_direct     <= u_direct;
				frm_bypass     <= u_bypass;
				if (slot >= last_slot) begin
					// following pixels continue in the next byte, or in the next byte pair for sixteen bit pixels
					slot      <= 3'h0;
					fetch_ptr <= pair_lo + ptr_step;
				end else begin
					slot <= slot + 3'h1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// read path, data one cycle after the strobe
	// ----------------------------------------------------------------
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			host_rdata <= 32'h0000_0000;
		end else if (host_rd) begin
			if (host_space_buf) begin
				host_rdata <= {24'h000000, mem[haddr]};
			end else if (is_reg(host_addr, `PPLI_REG_ID)) begin
				host_rdata <= id_word;
			end else if (is_reg(host_addr, `PPLI_REG_CTRL)) begin
				host_rdata <= {27'h0000000, color, 1'b0, depth};
			end else if (is_reg(host_addr, `PPLI_REG_FETCH)) begin
				host_rdata <= {{(32-BUF_AW){1'b0}}, fetch_base};
			end else if (is_reg(host_addr, `PPLI_REG_STAT)) begin
				host_rdata <= {{(29-BUF_AW){1'b0}}, slot, fetch_ptr};
			end else begin
				host_rdata <= 32'h0000_0000;
			end
		end else begin
			host_rdata <= 32'h0000_0000;
		end
	end

endmodule

// ===== ppli_unpack.v
// Purpose: splits one fetched buffer word into a pixel index or direct colour
// Assumes: word holds a byte pair, lower address in bits 7-0
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/1ps
`include "ppli_map.vh"

module ppli_unpack (
	// fetched data
	input  wire [15:0] word,
	input  wire [2:0]  depth,
	input  wire [2:0]  slot,
	input  wire        color,
	// result
	output reg  [7:0]  index,
	output reg  [15:0] direct,
	output reg         bypass
);

	wire [7:0] byte0;
	assign byte0 = word[7:0];

	always @* begin
		index  = 8'h00;
		direct = 16'h0000;
		bypass = 1'b0;
		case (depth)
		`PPLI_DEPTH_1: begin
			// slot 0 is the leftmost pixel, held in bit 7
			index = {7'h00, byte0[3'h7 - slot]};
		end
		`PPLI_DEPTH_2: begin
			index = {6'h00, byte0[(3'h3 - {1'b0, slot[1:0]}) * 2 +: 2]};
		end
		`PPLI_DEPTH_4: begin
			index = {4'h0, slot[0] ? byte0[3:0] : byte0[7:4]};
		end
		`PPLI_DEPTH_8: begin
			// mono keeps 64 levels, so 65 and 1 look alike
			index = color ? byte0 : {2'b00, byte0[5:0]};
		end
		`PPLI_DEPTH_16: begin
			bypass = 1'b1;
			// red high byte at the odd address; mono sends green only
			if (color) begin
				direct = {word[15:11], word[10:5], word[4:0]};
			end else begin
				direct = {10'h000, word[10:5]};
			end
		end
		default: begin
			index = 8'h00;
		end
		endcase
	end

endmodule

// ===== tb.sv
// Purpose: host port and pixel feed tests
// Assumes: small buffer parameter, straps fixed
// Notes:   identity codes given to the design are arbitrary
`timescale 1ns/1ps
module tb;
	reg         clk_sys = 1'b0;
	reg         rst_n = 1'b0;
	reg         sp = 1'b0;
	reg  [19:0] ad = 20'h0;
	reg  [31:0] wd = 32'h0;
	reg         wr = 1'b0;
	reg         rd = 1'b0;
	reg  [6:0]  straps = 7'h55;
	reg         pix_req = 1'b0;
	wire [31:0] host_rdata;
	wire        pix_valid;
	wire [7:0]  pal_index;
	wire        pal_green_only;
	wire [15:0] frm_direct;
	wire        frm_bypass;
	integer     err_count = 0;
	integer     comparisons = 0;
	integer     c, d, k, b;
	reg  [15:0] px;
	always #10 clk_sys = ~clk_sys;
	ppli_top #(.BUF_AW(6), .PROD(6'h15), .REV(2'h3)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.host_space_buf(sp), .host_addr(ad), .host_wdata(wd), .host_wr(wr), .host_rd(rd),
		.host_rdata(host_rdata), .config_strap_pins(straps), .pix_req(pix_req),
		.pix_valid(pix_valid), .pal_index(pal_index), .pal_green_only(pal_green_only),
		.frm_direct(frm_direct), .frm_bypass(frm_bypass));
	ppli_pal_model i_pal (.clk_sys(clk_sys), .pix_valid(pix_valid), .pal_index(pal_index),
		.pal_green_only(pal_green_only), .frm_direct(frm_direct), .frm_bypass(frm_bypass),
		.panel_rgb());
	task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
		begin
			comparisons = comparisons + 1;
			if (g !== e) begin
				err_count = err_count + 1;
				$display("[FAIL] %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task wreg(input s, input [19:0] a, input [31:0] v);
		begin
			@(posedge clk_sys);
			sp <= s;
			ad <= a;
			wd <= v;
			wr <= 1'b1;
			@(posedge clk_sys);
			wr <= 1'b0;
		end
	endtask
	task rreg(input s, input [19:0] a, input [31:0] e, input [63:0] nm);
		begin
			@(posedge clk_sys);
			sp <= s;
			ad <= a;
			rd <= 1'b1;
			@(posedge clk_sys);
			rd <= 1'b0;
			#1 chk(nm, e, host_rdata);
		end
	endtask
	task pix(input [31:0] e);
		begin
			@(posedge clk_sys);
			pix_req <= 1'b1;
			@(posedge clk_sys);
			pix_req <= 1'b0;
			#1 chk("pixel", e, {13'h0, pix_valid, pal_green_only, frm_bypass,
				frm_bypass ? frm_direct : {8'h0, pal_index}});
		end
	endtask
	task end_of_test;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, err_count);
			if (err_count == 0 && comparisons > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	initial begin
		#100000;
		err_count = err_count + 1;
		end_of_test;
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk_sys);
		rreg(0, 20'h0, {6'h15, 2'h3, 1'b0, straps, 8'h40, 6'h15, 2'h3}, "ident");
		rreg(0, 20'h10, 32'h0, "unmapped");
		wreg(0, 20'h8, 32'h0);
		wreg(0, 20'h4, 32'h0);
		for (k = 0; k < 64; k = k + 1)
			wreg(1, k[19:0], 32'h0);
		rreg(1, 20'h3f, 32'h0, "cleared");
		wreg(1, 20'h0, 32'hb4);
		wreg(1, 20'h1, 32'hc5);
		rreg(1, 20'h0, 32'hb4, "buffer");
		rreg(1, 20'h1, 32'hc5, "buffer");
		$display("test host port done");
		for (c = 0; c < 2; c = c + 1) begin
			for (d = 0; d < 5; d = d + 1) begin
				b = 1 << d;
				wreg(0, 20'h8, (d == 4) ? 32'h1 : 32'h0);
				wreg(0, 20'h4, {27'h0, c[0], 1'b0, d[2:0]});
				if (d == 4)
					pix({16'h0005, c ? 16'hc5b4 : 16'h002d});
				for (k = 0; d < 4 && k < 16 / b; k = k + 1) begin
					px = (16'hb4c5 >> (16 - b * (k + 1))) & ((1 << b) - 1);
					if (d == 3 && c == 0)
						px = px & 16'h3f;
					pix({16'h0004 | {15'h0, ~c[0]} << 1, px});
				end
			end
		end
		wreg(0, 20'h4, 32'h5);
		pix({16'h0006, 16'h0000});
		$display("test pixel modes done");
		end_of_test;
	end
endmodule
